// ==== src/usctx_pkg.sv ====
// usctx_pkg: constants, types and shared helpers for the usart clocking/framing/tx block
package usctx_pkg;

  // ----------------------------------------------------------------
  // widths and prescaler figures
  // ----------------------------------------------------------------
  localparam int          BAUD_W          = 12;     // baud divisor width, 0..4095
  localparam int          DATA_W          = 9;      // widest character
  localparam logic [3:0]  PRE_NORMAL_LAST = 4'hf;   // 16 baud ticks per bit
  localparam logic [3:0]  PRE_DOUBLE_LAST = 4'h7;   // 8 baud ticks per bit
  localparam logic [3:0]  PRE_NORMAL_MID  = 4'h8;   // preset so first sample is mid start bit
  localparam logic [3:0]  PRE_DOUBLE_MID  = 4'h4;   // same, double speed
  localparam logic [3:0]  BITS_FULL       = 4'h9;   // character width of the shift registers

  // ----------------------------------------------------------------
  // frame format encodings
  // ----------------------------------------------------------------
  localparam logic [2:0]  CSZ_5           = 3'h0;
  localparam logic [2:0]  CSZ_6           = 3'h1;
  localparam logic [2:0]  CSZ_7           = 3'h2;
  localparam logic [2:0]  CSZ_8           = 3'h3;
  localparam logic [2:0]  CSZ_9           = 3'h7;
  localparam int          PAR_EN_BIT      = 1;      // parity field bit that enables parity
  localparam int          PAR_ODD_BIT     = 0;      // parity field bit that selects odd

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [BAUD_W-1:0] BAUD_RST  = 12'h000;
  localparam logic        LINE_IDLE       = 1'b1;   // idle and stop level

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              syncModeSelect;    // 1 = synchronous
    logic              doubleSpeedBit;    // async only
    logic              clockPolarityBit;  // 0 = change on rising edge
    logic              clockPinDirection; // 1 = master, clock driven out
    logic [2:0]        characterSizeField;
    logic [1:0]        parityModeField;
    logic              stopBitsSelect;    // 1 = two stop bits
    logic              transmitEnableBit;
    logic              receiveEnable;
    logic [BAUD_W-1:0] baudDivisorSetting;
  } usctx_cfg_t;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2} usctx_tx_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} usctx_rx_t;

  typedef struct packed {
    logic [BAUD_W-1:0] baudCnt;   // baud down-counter
    logic [3:0]        txPre;     // transmit prescaler
    logic [3:0]        rxPre;     // receive sample counter
    logic              bitClk;    // master bit clock level
    logic              xSync1;    // synchroniser first stage
    logic              xSync2;    // synchroniser second stage
    logic              xSync3;    // edge detector history
    usctx_tx_t         txSt;
    logic              txLine;
    logic [DATA_W-1:0] txShift;
    logic              txPar;
    logic [3:0]        txCnt;
    logic [DATA_W-1:0] bufData;
    logic              bufFull;
    logic              txc;
    usctx_rx_t         rxSt;
    logic [DATA_W-1:0] rxShift;
    logic [3:0]        rxCnt;
    logic [DATA_W-1:0] rxData;
    logic              rxValid;
    logic              fe;
  } usctx_state_t;

  localparam usctx_state_t STATE_RST = '{baudCnt: BAUD_RST, txSt: TX_IDLE, rxSt: RX_IDLE,
                                         txLine: LINE_IDLE, default: '0};

  // ----------------------------------------------------------------
  // helpers: dataBits shared by transmitter and receiver, maskData used by the transmitter
  // ----------------------------------------------------------------
  // number of data bits for a size code; reserved codes fall back to eight
  function automatic logic [3:0] dataBits(input logic [2:0] size);
    case (size)
      CSZ_5:   dataBits = 4'h5;
      CSZ_6:   dataBits = 4'h6;
      CSZ_7:   dataBits = 4'h7;
      CSZ_8:   dataBits = 4'h8;
      CSZ_9:   dataBits = 4'h9;
      default: dataBits = 4'h8;
    endcase
  endfunction

  // clears the bits above the character size
  function automatic logic [DATA_W-1:0] maskData(input logic [DATA_W-1:0] data,
                                                 input logic [3:0]        n);
    maskData = data & ((9'h001 << n) - 9'h001);
  endfunction

endpackage

// ==== src/usctx_top.sv ====
// usctx_top: baud generation, bit clock handling, frame transmitter and simple receiver
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Functional notes
// - double speed divides baud output by 8
// - double speed ignored in synchronous mode
// - double speed receiver uses 8 samples
// - bit clock input synchronised then edge detected
// - sync mode: clock pin input slave, output master
// - sample opposite edge to data change
// - polarity selects change and sample edges
// - 5-9 data, parity options, 1-2 stops
// - start, data lsb first, parity, stops
// - next frame follows directly or line idles
// - start low, stop and idle high
// - one format setting shared by both directions
// - only first stop bit checked for error
// - parity is xor, inverted for odd
// - transmit enable takes over serial out pin
// - sync transmit uses bit clock pin
// - data write loads buffer, starts transmission
// - buffer moves to shifter when idle or frame ends
// - unused high data bits ignored
// - baud down-counter reloads at zero or write
// - transmitter divides ticks by 2, 8 or 16
// - clock pin direction selects master or slave
// - buffer empty flag clears on data write
// ------------------------------------------------------------------
module usctx_top (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  clkEn,
  input  wire usctx_pkg::usctx_cfg_t cfg,
  input  wire logic                  baudLowWrite,
  input  wire logic                  txWrite,
  input  wire logic [8:0]            txData,
  input  wire logic                  txcClear,
  input  wire logic                  serialInPin,
  input  wire logic                  bitClockPinIn,
  output logic                       serialOutPin,
  output logic                       serialOutOe,
  output logic                       bitClockPinOut,
  output logic                       bitClockPinOe,
  output logic                       bufferEmptyFlag,
  output logic                       transmitCompleteFlag,
  output logic [8:0]                 rxData,
  output logic                       rxValid,
  output logic                       frameErrorFlag
);
  import usctx_pkg::*;

  // ----------------------------------------------------------------
  // state and decoded control
  // ----------------------------------------------------------------
  usctx_state_t      q;           // registered state
  usctx_state_t      d;           // next state
  logic              isSync;      // synchronous operation
  logic              isMaster;    // synchronous master
  logic              baudTick;    // one tick per counter zero
  logic [3:0]        preLast;     // last prescaler count
  logic [3:0]        preMid;      // receive start preset
  logic              rawRise;     // detected rising edge of pin
  logic              rawFall;     // detected falling edge of pin
  logic              changeEdge;  // bit clock edge that moves data out
  logic              sampleEdge;  // bit clock edge that samples data in
  logic              txTick;      // one transmit bit time elapsed
  logic              rxSample;    // receive sample point
  logic [3:0]        nBits;       // data bits in the frame
  logic              parEn;       // parity bit present
  logic              loadReq;     // move buffer into shifter
  logic              endFrame;    // last stop bit finished
  logic [DATA_W-1:0] loadData;    // masked buffer contents

  // shared format decode: both directions read the same fields
  assign nBits    = dataBits(cfg.characterSizeField);
  assign parEn    = cfg.parityModeField[PAR_EN_BIT];
  assign loadData = maskData(q.bufData, nBits);
  assign isSync   = cfg.syncModeSelect;
  assign isMaster = isSync & cfg.clockPinDirection;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  // one process for the whole block keeps the clock-enable freeze trivial
  always_comb begin
    d          = q;
    d.rxValid  = 1'b0;
    loadReq    = 1'b0;
    endFrame   = 1'b0;

    // baud generator: tick at zero, reload at zero or on a low-byte write
    baudTick = (q.baudCnt == '0);
    if (baudLowWrite || baudTick) begin
      d.baudCnt = cfg.baudDivisorSetting;
    end else begin
      d.baudCnt = q.baudCnt - 12'h001;
    end

    // double speed only shortens the async prescaler; sync ignores it
    preLast = cfg.doubleSpeedBit ? PRE_DOUBLE_LAST : PRE_NORMAL_LAST;
    preMid  = cfg.doubleSpeedBit ? PRE_DOUBLE_MID : PRE_NORMAL_MID;

    // external clock: two stages then edge detect, two cycles of delay
    d.xSync1 = bitClockPinIn;
    d.xSync2 = q.xSync1;
    d.xSync3 = q.xSync2;
    rawRise  = q.xSync2 & ~q.xSync3;
    rawFall  = ~q.xSync2 & q.xSync3;

    // master clock toggles per baud tick, giving the divide by two
    if (isMaster) begin
      if (baudTick) begin
        d.bitClk = ~q.bitClk;
      end
    end else begin
      d.bitClk = cfg.clockPolarityBit;  // parked at the level before a change edge
    end

    // edge roles follow polarity; sampling always on the other edge
    if (isMaster) begin
      changeEdge = baudTick & (q.bitClk == cfg.clockPolarityBit);
      sampleEdge = baudTick & (q.bitClk != cfg.clockPolarityBit);
    end else begin
      changeEdge = isSync & (cfg.clockPolarityBit ? rawFall : rawRise);
      sampleEdge = isSync & (cfg.clockPolarityBit ? rawRise : rawFall);
    end

    // transmit prescaler: 16 or 8 ticks async, the bit clock when sync
    if (baudTick) begin
      d.txPre = (q.txPre == preLast) ? 4'h0 : q.txPre + 4'h1;
    end
    txTick = isSync ? changeEdge : (baudTick & (q.txPre == preLast));

    // buffer write: always accepted, overwrites unsent data
    if (txWrite) begin
      d.bufData = txData;
      d.bufFull = 1'b1;
    end
    if (txcClear) begin
      d.txc = 1'b0;
    end

    // transmit sequencer: state names the bit now on the line
    if (txTick) begin
      case (q.txSt)
        TX_IDLE: begin
          loadReq = q.bufFull & cfg.transmitEnableBit;
        end
        TX_START: begin
          d.txLine  = q.txShift[0];
          d.txShift = q.txShift >> 1;
          d.txCnt   = 4'h1;
          d.txSt    = TX_DATA;
        end
        TX_DATA: begin
          if (q.txCnt < nBits) begin
            d.txLine  = q.txShift[0];
            d.txShift = q.txShift >> 1;
            d.txCnt   = q.txCnt + 4'h1;
          end else if (parEn) begin
            d.txLine = q.txPar;
            d.txSt   = TX_PAR;
          end else begin
            d.txLine = LINE_IDLE;
            d.txSt   = TX_STOP1;
          end
        end
        TX_PAR: begin
          d.txLine = LINE_IDLE;
          d.txSt   = TX_STOP1;
        end
        TX_STOP1: begin
          if (cfg.stopBitsSelect) begin
            d.txSt = TX_STOP2;
          end else begin
            endFrame = 1'b1;
          end
        end
        TX_STOP2: begin
          endFrame = 1'b1;
        end
        default: begin
          d.txSt = TX_IDLE;
        end
      endcase
    end

    // pending data follows back to back, even if enable was just dropped
    if (endFrame) begin
      if (q.bufFull) begin
        loadReq = 1'b1;
      end else begin
        d.txSt   = TX_IDLE;
        d.txLine = LINE_IDLE;
        d.txc    = 1'b1;  // set after the clear so a same-cycle event survives
      end
    end

    // shifter load drives the start bit at once; a write in this cycle refills
    if (loadReq) begin
      d.txLine  = 1'b0;
      d.txShift = loadData;
      d.txPar   = (^loadData) ^ cfg.parityModeField[PAR_ODD_BIT];
      d.txSt    = TX_START;
      d.bufFull = txWrite;
    end

    // receive sample counter; async only
    if (baudTick) begin
      d.rxPre = (q.rxPre == preLast) ? 4'h0 : q.rxPre + 4'h1;
    end
    rxSample = isSync ? sampleEdge : (baudTick & (q.rxPre == preLast));

    // receiver: just enough framing to check the first stop bit
    case (q.rxSt)
      RX_IDLE: begin
        if (cfg.receiveEnable && !serialInPin) begin
          if (isSync) begin
            if (sampleEdge) begin
              d.rxSt  = RX_DATA;
              d.rxCnt = 4'h0;
            end
          end else begin
            d.rxPre = preMid;   // half a bit lands the samples mid-bit
            d.rxSt  = RX_START;
          end
        end
      end
      RX_START: begin
        if (rxSample) begin
          // a high start sample is a glitch, not a frame
          d.rxSt  = serialInPin ? RX_IDLE : RX_DATA;
          d.rxCnt = 4'h0;
        end
      end
      RX_DATA: begin
        if (rxSample) begin
          d.rxShift = {serialInPin, q.rxShift[DATA_W-1:1]};
          d.rxCnt   = q.rxCnt + 4'h1;
          if (q.rxCnt + 4'h1 == nBits) begin
            d.rxSt = parEn ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (rxSample) begin
          d.rxSt = RX_STOP;  // parity checking is outside this block
        end
      end
      RX_STOP: begin
        if (rxSample) begin
          d.rxValid = 1'b1;
          d.fe      = ~serialInPin;
          d.rxData  = q.rxShift >> (BITS_FULL - nBits);
          d.rxSt    = RX_IDLE;  // a second stop bit is never looked at
        end
      end
      default: begin
        d.rxSt = RX_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= STATE_RST;
    end else if (clkEn) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // pin stays ours until shifter and buffer drain after enable drops
  assign serialOutOe          = cfg.transmitEnableBit | (q.txSt != TX_IDLE) | q.bufFull;
  assign serialOutPin         = q.txLine;
  assign bitClockPinOut       = q.bitClk;
  assign bitClockPinOe        = isMaster;
  assign bufferEmptyFlag      = ~q.bufFull;
  assign transmitCompleteFlag = q.txc;
  assign rxData               = q.rxData;
  assign rxValid              = q.rxValid;
  assign frameErrorFlag       = q.fe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_baudReload;
    @(posedge clk) disable iff (!rst_n)
      clkEn && q.baudCnt == '0 |=> q.baudCnt == $past(cfg.baudDivisorSetting);
  endproperty
  a_baudReload: assert property (p_baudReload) else $error("baud counter not reloaded");

  property p_doubleDiv;
    @(posedge clk) disable iff (!rst_n)
      !isSync && cfg.doubleSpeedBit && baudTick && q.txPre == 4'h7 |-> txTick;
  endproperty
  a_doubleDiv: assert property (p_doubleDiv) else $error("double speed tick missing");

  property p_normalDiv;
    @(posedge clk) disable iff (!rst_n)
      !isSync && !cfg.doubleSpeedBit && txTick |-> q.txPre == 4'hf;
  endproperty
  a_normalDiv: assert property (p_normalDiv) else $error("normal tick off count");

  property p_edgeDelay;
    @(posedge clk) disable iff (!rst_n)
      clkEn && $rose(bitClockPinIn) ##1 clkEn |=> rawRise;
  endproperty
  a_edgeDelay: assert property (p_edgeDelay) else $error("edge not seen two cycles on");

  property p_startLow;
    @(posedge clk) disable iff (!rst_n)
      (q.txSt == TX_START |-> !serialOutPin) and (q.txSt == TX_IDLE |-> serialOutPin);
  endproperty
  a_startLow: assert property (p_startLow) else $error("start or idle level wrong");

  property p_parity;
    @(posedge clk) disable iff (!rst_n)
      clkEn && loadReq |=> q.txPar == ($past(^loadData) ^ $past(cfg.parityModeField[0]));
  endproperty
  a_parity: assert property (p_parity) else $error("parity bit wrong");

  property p_bufWrite;
    @(posedge clk) disable iff (!rst_n)
      clkEn && txWrite |=> !bufferEmptyFlag && q.bufData == $past(txData);
  endproperty
  a_bufWrite: assert property (p_bufWrite) else $error("write did not fill buffer");

  property p_stopCheck;
    @(posedge clk) disable iff (!rst_n)
      clkEn && rxSample && q.rxSt == RX_STOP |=> rxValid && frameErrorFlag == !$past(serialInPin);
  endproperty
  a_stopCheck: assert property (p_stopCheck) else $error("stop bit check wrong");

  property p_pinOwn;
    @(posedge clk) disable iff (!rst_n)
      (cfg.transmitEnableBit |-> serialOutOe) and (bitClockPinOe == (isSync && cfg.clockPinDirection));
  endproperty
  a_pinOwn: assert property (p_pinOwn) else $error("pin ownership wrong");

endmodule

// ==== tb/usctx_peer.sv ====
// usctx_peer: behavioural remote serial transceiver on the far side of the line pins
`timescale 1ns/1ps
// ------------------------------------------------------------------
// remote line model
// ------------------------------------------------------------------
module usctx_peer (
  input  wire logic lineIn,   // transmit line from the block
  input  wire logic clk,      // system clock, used only as a time base
  output logic      lineOut   // receive line into the block
);
  // the line has a pull-up, so released means high
  initial lineOut = 1'b1;

  // waits for a start bit, then samples each bit in its middle, lsb first
  task automatic grab(input int nb, input int bl, output logic [13:0] f);
    int i;
    f = '1;
    for (i = 0; i < 3000 && lineIn !== 1'b0; i++) @(negedge clk);
    repeat (bl / 2) @(negedge clk);
    for (i = 0; i < nb; i++) begin
      f[i] = lineIn;
      if (i < nb - 1) repeat (bl) @(negedge clk);
    end
  endtask

  // drives a whole frame, one bit time per bit, then releases to idle high
  task automatic send(input logic [13:0] f, input int nb, input int bl);
    int i;
    for (i = 0; i < nb; i++) begin
      lineOut = f[i];
      repeat (bl) @(negedge clk);
    end
    lineOut = 1'b1;
  endtask
endmodule

// ==== tb/tb_top.sv ====
// tb_top: self-checking bench for the usart clocking, framing and transmit block
`timescale 1ns/1ps
module tb_top;
  import usctx_pkg::*;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic       clk, rst_n, txWrite, txcClear, baudLowWrite, serialOutPin, serialOutOe;
  logic       bitClockPinOut, bitClockPinOe, bufferEmptyFlag, txc, rxValid, fe, serialInPin;
  logic [8:0] txData, rxData;
  logic       clkEn, slaveClk;  // freeze control and slave bit clock, both from the bench
  usctx_cfg_t cfg;            // all configuration bits
  int         miscompares;    // failed comparisons
  int         n_checks;       // comparisons made
  int         cyc;            // cycle count for the hang guard

  usctx_top usctx_top_inst (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .cfg(cfg),
    .baudLowWrite(baudLowWrite), .txWrite(txWrite), .txData(txData), .txcClear(txcClear),
    .serialInPin(serialInPin), .bitClockPinIn(slaveClk), .serialOutPin(serialOutPin),
    .serialOutOe(serialOutOe), .bitClockPinOut(bitClockPinOut), .bitClockPinOe(bitClockPinOe),
    .bufferEmptyFlag(bufferEmptyFlag), .transmitCompleteFlag(txc), .rxData(rxData),
    .rxValid(rxValid), .frameErrorFlag(fe));
  usctx_peer usctx_peer_inst (.lineIn(serialOutPin), .clk(clk), .lineOut(serialInPin));

  // ------------------------------------------------------------------
  // clock, hang guard, helpers
  // ------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // the full run needs well under 20k cycles; reaching 40000 is a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  // data bits for the current size code
  function automatic int nBits();
    return (cfg.characterSizeField == 3'h7) ? 9 : 5 + int'(cfg.characterSizeField[1:0]);
  endfunction
  // baud ticks per bit at setting 0
  function automatic int bl();
    return cfg.doubleSpeedBit ? 8 : 16;
  endfunction
  // expected line image, lsb first: start, data, parity, stops
  function automatic logic [13:0] mkFrame(input logic [8:0] d, output int nb);
    logic [13:0] f;
    logic [8:0]  m;
    int          i;
    m = d & ((9'h001 << nBits()) - 9'h001);
    f = '1;
    f[0] = 1'b0;
    nb = 1;
    for (i = 0; i < nBits(); i++) begin
      f[nb] = m[i];
      nb++;
    end
    if (cfg.parityModeField[1]) begin
      f[nb] = ^m ^ cfg.parityModeField[0];
      nb++;
    end
    nb += 1 + int'(cfg.stopBitsSelect);
    return f;
  endfunction
  // format row: size[6:4], parity[3:2], two stops[1], double speed[0]
  task automatic setFmt(input logic [6:0] r);
    cfg.characterSizeField = r[6:4];
    cfg.parityModeField = r[3:2];
    cfg.stopBitsSelect = r[1];
    cfg.doubleSpeedBit = r[0];
  endtask
  task automatic wr(input logic [8:0] d);
    txData = d;
    txWrite = 1'b1;
    @(negedge clk);
    txWrite = 1'b0;
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  // two frames back to back, then idle, flags and flag clear
  task automatic txPair(input logic [6:0] r, input logic [8:0] d0, input logic [8:0] d1);
    logic [13:0] g0, g1, e0, e1;
    int          nb, i;
    setFmt(r);
    e0 = mkFrame(d0, nb);
    e1 = mkFrame(d1, nb);
    fork
      begin
        usctx_peer_inst.grab(nb, bl(), g0);
        usctx_peer_inst.grab(nb, bl(), g1);
      end
      begin
        wr(d0);
        check(bufferEmptyFlag, 0, "buffer flag after write");
        for (i = 0; i < 300 && bufferEmptyFlag !== 1'b1; i++) @(negedge clk);
        wr(d1);
      end
    join
    check(g0, e0, "first frame");
    check(g1, e1, "second frame");
    repeat (bl() + 4) @(negedge clk);
    check(serialOutPin, 1, "idle line");
    check(txc, 1, "transmit complete");
    txcClear = 1'b1;
    @(negedge clk);
    txcClear = 1'b0;
    check(txc, 0, "complete flag cleared");
  endtask

  // remote sends a frame; the first stop may be forced low
  task automatic rxOne(input logic [6:0] r, input logic [8:0] d, input logic bad);
    logic [13:0] f;
    int          nb, i;
    setFmt(r);
    f = mkFrame(d, nb);
    if (bad) f[nb - 1 - int'(cfg.stopBitsSelect)] = 1'b0;
    fork
      usctx_peer_inst.send(f, nb, bl());
      begin
        for (i = 0; i < 400 && rxValid !== 1'b1; i++) @(negedge clk);
        check(rxValid, 1, "receive strobe");
        check(rxData, d & ((9'h001 << nBits()) - 9'h001), "received data");
        check(fe, bad, "frame error");
      end
    join
    repeat (bl()) @(negedge clk);
  endtask

  // master clock toggles once per baud tick; pin direction follows mode
  task automatic syncClock();
    logic prev;
    int   n, i;
    cfg.doubleSpeedBit = 1'b0;
    cfg.syncModeSelect = 1'b1;
    cfg.clockPinDirection = 1'b1;
    @(negedge clk);
    check(bitClockPinOe, 1, "master drives clock pin");
    n = 0;
    prev = bitClockPinOut;
    for (i = 0; i < 20; i++) begin
      @(negedge clk);
      if (bitClockPinOut !== prev) n++;
      prev = bitClockPinOut;
    end
    check(n, 20, "master clock toggles");
    // an odd number of frozen cycles would show a toggle if the enable were ignored
    prev = bitClockPinOut;
    clkEn = 1'b0;
    repeat (3) @(negedge clk);
    check(bitClockPinOut, prev, "enable low freezes clock");
    clkEn = 1'b1;
    cfg.clockPinDirection = 1'b0;
    @(negedge clk);
    check(bitClockPinOe, 0, "slave leaves clock pin");
    cfg.syncModeSelect = 1'b0;
    @(negedge clk);
  endtask

  // slave transmit: bench clocks the pin at an eighth of the system clock
  task automatic slaveTx(input logic pol, input logic [8:0] d);
    logic [13:0] g, e;
    int          nb, k;
    setFmt(7'b011_10_0_0);
    cfg.syncModeSelect = 1'b1;
    cfg.clockPinDirection = 1'b0;
    cfg.clockPolarityBit = pol;
    slaveClk = pol;  // park at the level before a change edge
    e = mkFrame(d, nb);
    g = '1;
    repeat (4) @(negedge clk);
    txcClear = 1'b1;
    @(negedge clk);
    txcClear = 1'b0;
    wr(d);
    for (k = 0; k <= nb; k++) begin
      slaveClk = ~pol;
      repeat (4) @(negedge clk);
      if (k < nb) g[k] = serialOutPin;
      slaveClk = pol;
      repeat (4) @(negedge clk);
    end
    check(g, e, "slave frame");
    check(txc, 1, "slave frame complete");
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  logic [6:0] rows [5] = '{7'b000_10_0_0, 7'b001_11_1_1, 7'b010_00_0_1,
                           7'b011_11_0_0, 7'b111_10_1_0};
  initial begin
    cfg = '0;
    cfg.transmitEnableBit = 1'b1;
    cfg.receiveEnable = 1'b1;
    {rst_n, txWrite, txcClear, baudLowWrite, txData} = '0;
    clkEn = 1'b1;
    slaveClk = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    check(serialOutPin, 1, "reset line level");
    check(bufferEmptyFlag, 1, "reset buffer flag");
    check(serialOutOe, 1, "enable owns pin");
    baudLowWrite = 1'b1;
    @(negedge clk);
    baudLowWrite = 1'b0;
    foreach (rows[k]) txPair(rows[k], 9'h1a5, 9'h0ca);
    rxOne(7'b011_00_0_0, 9'h0b6, 1'b0);
    rxOne(7'b010_10_1_1, 9'h05b, 1'b1);
    syncClock();
    slaveTx(1'b0, 9'h0d3);
    slaveTx(1'b1, 9'h12c);
    close_out();
  end
endmodule
